// ---- rcc_control_regs.sv ----
// rate converter control and status register bank behind the serial host port
// assumes a host port decoder giving one-cycle read/write strobes and a 7-bit address
`timescale 1ns/1ps
`default_nettype none
`include "rcc_consts.svh"

module rcc_control_regs (
	input  wire logic                clk_sys,
	input  wire logic                reset_n,
	input  wire logic                hostWr,
	input  wire logic                hostRd,
	input  wire logic [6:0]          hostAddr,
	input  wire logic [7:0]          hostWrData,
	output logic      [7:0]          hostRdData,
	output logic                     hostRdValid,
	output rcc_pkg::rcc_page_t       bufPage,
	output rcc_pkg::rcc_buf_wr_t     bufWrite,
	input  wire logic [7:0]          bufRdData,
	input  wire rcc_pkg::rcc_ratio_t ratioMeasured,
	input  wire logic [15:0]         burstLenPreamble,
	input  wire logic [7:0]          rxCsByte0,
	input  wire logic [7:0]          rxCsByte3,
	output rcc_pkg::rcc_cfg_t        convCfg,
	output logic      [1:0]          txProMode
);
	import rcc_pkg::*;

	// ==================================================================
	// register state
	logic [7:0]  srcMute_r, srcMute_nxt;
	logic [7:0]  filter_r, filter_nxt;
	logic [7:0]  wordLen_r, wordLen_nxt;
	logic [7:0]  attenL_r, attenL_nxt;
	logic [7:0]  attenR_r, attenR_nxt;
	logic [7:0]  page_r, page_nxt;
	logic [7:0]  ratioLowShadow_r, ratioLowShadow_nxt;
	logic [7:0]  rdData_r, rdData_nxt;
	logic        rdValid_r, rdValid_nxt;
	logic [1:0]  txPro_r, txPro_nxt;
	rcc_buf_wr_t bufWr_r, bufWr_nxt;
	rcc_cfg_t    cfg_r, cfg_nxt;

	logic [1:0]  srcHeld;
	logic [1:0]  clkHeld;
	logic [1:0]  pageHeld;
	logic        onCtrlPage;
	logic        isPageAddr;
	logic [15:0] ratioWord;
	rcc_deemph_t autoDeemph;

	// ==================================================================
	// reserved codes keep the previous selection
	rcc_sel_hold #(.W(2), .RESERVED(`RCC_SEL_RESERVED)) srcHold (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.code     (srcMute_r[`RCC_POS_INPUT_SRC +: 2]),
		.heldCode (srcHeld)
	);

	rcc_sel_hold #(.W(2), .RESERVED(`RCC_SEL_RESERVED)) clkHold (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.code     (srcMute_r[`RCC_POS_REF_CLK +: 2]),
		.heldCode (clkHeld)
	);

	rcc_sel_hold #(.W(2), .RESERVED(`RCC_SEL_RESERVED)) pageHold (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.code     (page_nxt[`RCC_POS_PAGE +: 2]),
		.heldCode (pageHeld)
	);

	// ==================================================================
	// decode
	assign isPageAddr = (hostAddr == `RCC_OFF_PAGE_SELECT);
	assign onCtrlPage = (rcc_page_t'(pageHeld) == RCC_PAGE_CTRL);
	assign ratioWord  = {ratioMeasured.ratioInteger, ratioMeasured.ratioFraction};

	// ==================================================================
	// automatic de-emphasis from receiver channel status
	always_comb begin
		autoDeemph = RCC_DEEMPH_OFF;
		if (rxCsByte0[`RCC_POS_CS_PRO_MODE]) begin
			if (rxCsByte0[5:3] == `RCC_CS_PRO_EMPH_5015) begin
				unique case (rxCsByte0[1:0])
					`RCC_CS_PRO_FS_48: autoDeemph = RCC_DEEMPH_48;
					`RCC_CS_PRO_FS_44: autoDeemph = RCC_DEEMPH_44;
					`RCC_CS_PRO_FS_32: autoDeemph = RCC_DEEMPH_32;
					default:           autoDeemph = RCC_DEEMPH_OFF;
				endcase
			end
		end else if (rxCsByte0[4:2] == `RCC_CS_CON_EMPH_5015) begin
			unique case (rxCsByte3[7:4])
				`RCC_CS_CON_FS_44: autoDeemph = RCC_DEEMPH_44;
				`RCC_CS_CON_FS_48: autoDeemph = RCC_DEEMPH_48;
				`RCC_CS_CON_FS_32: autoDeemph = RCC_DEEMPH_32;
				default:           autoDeemph = RCC_DEEMPH_OFF;
			endcase
		end
	end

	// ==================================================================
	// host writes and reads
	always_comb begin
		srcMute_nxt        = srcMute_r;
		filter_nxt         = filter_r;
		wordLen_nxt        = wordLen_r;
		attenL_nxt         = attenL_r;
		attenR_nxt         = attenR_r;
		page_nxt           = page_r;
		ratioLowShadow_nxt = ratioLowShadow_r;
		txPro_nxt          = txPro_r;
		rdData_nxt         = 8'h00;
		rdValid_nxt        = hostRd;
		bufWr_nxt          = '0;
		bufWr_nxt.page     = rcc_page_t'(pageHeld);
		bufWr_nxt.addr     = hostAddr;
		bufWr_nxt.data     = hostWrData;

		if (hostWr) begin
			if (isPageAddr) begin
				page_nxt = hostWrData & `RCC_MASK_PAGE;
			end else if (onCtrlPage) begin
				unique case (hostAddr)
					`RCC_OFF_SOURCE_MUTE: srcMute_nxt = hostWrData & `RCC_MASK_SOURCE_MUTE;
					`RCC_OFF_FILTER:      filter_nxt  = hostWrData & `RCC_MASK_FILTER;
					`RCC_OFF_WORD_LENGTH: wordLen_nxt = hostWrData & `RCC_MASK_WORD_LENGTH;
					`RCC_OFF_LEFT_ATTEN:  attenL_nxt  = hostWrData;
					`RCC_OFF_RIGHT_ATTEN: attenR_nxt  = hostWrData;
					default:              attenL_nxt  = attenL_r;
				endcase
			end else begin
				bufWr_nxt.wrEn = 1'b1;
				if (rcc_page_t'(pageHeld) == RCC_PAGE_XMIT) begin
					if (hostAddr == `RCC_OFF_TX_CS0_CH1) begin
						txPro_nxt[0] = hostWrData[`RCC_POS_CS_PRO_MODE];
					end
					if (hostAddr == `RCC_OFF_TX_CS0_CH2) begin
						txPro_nxt[1] = hostWrData[`RCC_POS_CS_PRO_MODE];
					end
					// byte 23 belongs to the crc generator in professional mode
					if ((hostAddr == `RCC_OFF_TX_CS23_CH1 && txPro_r[0]) ||
						(hostAddr == `RCC_OFF_TX_CS23_CH2 && txPro_r[1])) begin
						bufWr_nxt.wrEn = 1'b0;
					end
				end
			end
		end

		if (hostRd) begin
			if (isPageAddr) begin
				rdData_nxt = page_r;
			end else if (onCtrlPage) begin
				unique case (hostAddr)
					`RCC_OFF_BURST_HIGH:  rdData_nxt = burstLenPreamble[15:8];
					`RCC_OFF_BURST_LOW:   rdData_nxt = burstLenPreamble[7:0];
					`RCC_OFF_SOURCE_MUTE: rdData_nxt = srcMute_r;
					`RCC_OFF_FILTER:      rdData_nxt = filter_r;
					`RCC_OFF_WORD_LENGTH: rdData_nxt = wordLen_r;
					`RCC_OFF_LEFT_ATTEN:  rdData_nxt = attenL_r;
					`RCC_OFF_RIGHT_ATTEN: rdData_nxt = attenR_r;
					`RCC_OFF_RATIO_HIGH: begin
						rdData_nxt         = ratioWord[15:8];
						ratioLowShadow_nxt = ratioWord[7:0];
					end
					`RCC_OFF_RATIO_LOW:   rdData_nxt = ratioLowShadow_r;
					default:              rdData_nxt = 8'h00;
				endcase
			end else begin
				rdData_nxt = bufRdData;
			end
		end
	end

	// ==================================================================
	// effective converter settings
	always_comb begin
		cfg_nxt          = '0;
		cfg_nxt.inputSrc = rcc_src_t'(srcHeld);
		cfg_nxt.refClk   = rcc_clk_t'(clkHeld);
		cfg_nxt.mute     = srcMute_r[`RCC_POS_MUTE];
		cfg_nxt.attenLeft = attenL_r;
		cfg_nxt.attenRight = srcMute_r[`RCC_POS_TRACK] ? attenL_r : attenR_r;
		unique case (filter_r[`RCC_POS_GROUP_DELAY +: 2])
			2'h0: cfg_nxt.preBufSamples = `RCC_PREBUF_0;
			2'h1: cfg_nxt.preBufSamples = `RCC_PREBUF_1;
			2'h2: cfg_nxt.preBufSamples = `RCC_PREBUF_2;
			2'h3: cfg_nxt.preBufSamples = `RCC_PREBUF_3;
		endcase
		cfg_nxt.directDown = filter_r[`RCC_POS_DIRECT_DOWN];
		if (filter_r[`RCC_POS_AUTO_DEEMPH]) begin
			cfg_nxt.deemph = autoDeemph;
		end else begin
			cfg_nxt.deemph = rcc_deemph_t'(filter_r[`RCC_POS_DEEMPH +: 2]);
		end
		unique case (wordLen_r[`RCC_POS_WORD_LEN +: 2])
			2'h0: cfg_nxt.outWordBits = `RCC_WLEN_0;
			2'h1: cfg_nxt.outWordBits = `RCC_WLEN_1;
			2'h2: cfg_nxt.outWordBits = `RCC_WLEN_2;
			2'h3: cfg_nxt.outWordBits = `RCC_WLEN_3;
		endcase
		cfg_nxt.ditherEn = (wordLen_r[`RCC_POS_WORD_LEN +: 2] != 2'h0);
	end

	// ==================================================================
	// registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			srcMute_r        <= `RCC_RST_CTRL;
			filter_r         <= `RCC_RST_CTRL;
			wordLen_r        <= `RCC_RST_CTRL;
			attenL_r         <= `RCC_RST_CTRL;
			attenR_r         <= `RCC_RST_CTRL;
			page_r           <= `RCC_RST_CTRL;
			ratioLowShadow_r <= 8'h00;
			rdData_r         <= 8'h00;
			rdValid_r        <= 1'b0;
			txPro_r          <= 2'h0;
			bufWr_r          <= '0;
			cfg_r            <= '0;
		end else begin
			srcMute_r        <= srcMute_nxt;
			filter_r         <= filter_nxt;
			wordLen_r        <= wordLen_nxt;
			attenL_r         <= attenL_nxt;
			attenR_r         <= attenR_nxt;
			page_r           <= page_nxt;
			ratioLowShadow_r <= ratioLowShadow_nxt;
			rdData_r         <= rdData_nxt;
			rdValid_r        <= rdValid_nxt;
			txPro_r          <= txPro_nxt;
			bufWr_r          <= bufWr_nxt;
			cfg_r            <= cfg_nxt;
		end
	end

	assign hostRdData  = rdData_r;
	assign hostRdValid = rdValid_r;
	assign bufPage     = rcc_page_t'(pageHeld);
	assign bufWrite    = bufWr_r;
	assign convCfg     = cfg_r;
	assign txProMode   = txPro_r;

endmodule

`default_nettype wire

// ---- rcc_consts.svh ----
// rate converter control register constants: offsets, field positions, resets, codes
// assumes inclusion by bare name from the package and the design modules
`ifndef RCC_CONSTS_SVH
`define RCC_CONSTS_SVH

// register offsets, page 0
`define RCC_OFF_BURST_HIGH      7'h2B
`define RCC_OFF_BURST_LOW       7'h2C
`define RCC_OFF_SOURCE_MUTE     7'h2D
`define RCC_OFF_FILTER          7'h2E
`define RCC_OFF_WORD_LENGTH     7'h2F
`define RCC_OFF_LEFT_ATTEN      7'h30
`define RCC_OFF_RIGHT_ATTEN     7'h31
`define RCC_OFF_RATIO_HIGH      7'h32
`define RCC_OFF_RATIO_LOW       7'h33
`define RCC_OFF_PAGE_SELECT     7'h7F

// transmitter buffer page offsets of channel status bytes 0 and 23
`define RCC_OFF_TX_CS0_CH1      7'h00
`define RCC_OFF_TX_CS0_CH2      7'h01
`define RCC_OFF_TX_CS23_CH1     7'h2E
`define RCC_OFF_TX_CS23_CH2     7'h2F

// field positions
`define RCC_POS_INPUT_SRC       0
`define RCC_POS_REF_CLK         2
`define RCC_POS_MUTE            4
`define RCC_POS_TRACK           6
`define RCC_POS_GROUP_DELAY     0
`define RCC_POS_DIRECT_DOWN     2
`define RCC_POS_DEEMPH          3
`define RCC_POS_AUTO_DEEMPH     5
`define RCC_POS_WORD_LEN        6
`define RCC_POS_PAGE            0
// channel status bit 0 is the register msb
`define RCC_POS_CS_PRO_MODE     7

// writable bit masks; all other bits read zero
`define RCC_MASK_SOURCE_MUTE    8'h5F
`define RCC_MASK_FILTER         8'h3F
`define RCC_MASK_WORD_LENGTH    8'hC0
`define RCC_MASK_PAGE           8'h03

// reset values
`define RCC_RST_CTRL            8'h00

// pre-buffer depths and word lengths per code
`define RCC_PREBUF_0            7'd64
`define RCC_PREBUF_1            7'd32
`define RCC_PREBUF_2            7'd16
`define RCC_PREBUF_3            7'd8
`define RCC_WLEN_0              5'd24
`define RCC_WLEN_1              5'd20
`define RCC_WLEN_2              5'd18
`define RCC_WLEN_3              5'd16

// reserved selection code
`define RCC_SEL_RESERVED        2'h3

// channel status emphasis and rate codes, register bit order
`define RCC_CS_PRO_EMPH_5015    3'h7
`define RCC_CS_PRO_FS_48        2'h1
`define RCC_CS_PRO_FS_44        2'h2
`define RCC_CS_PRO_FS_32        2'h3
`define RCC_CS_CON_EMPH_5015    3'h4
`define RCC_CS_CON_FS_44        4'h0
`define RCC_CS_CON_FS_48        4'h4
`define RCC_CS_CON_FS_32        4'hC

`endif

// ---- rcc_pkg.sv ----
// rate converter control types shared by the register bank and its users
// assumes rcc_consts.svh alongside
`default_nettype none
`include "rcc_consts.svh"

package rcc_pkg;

	typedef enum logic [1:0] {
		RCC_SRC_PORT_A   = 2'h0,
		RCC_SRC_PORT_B   = 2'h1,
		RCC_SRC_RECEIVER = 2'h2,
		RCC_SRC_RSVD     = 2'h3
	} rcc_src_t;

	typedef enum logic [1:0] {
		RCC_CLK_MASTER    = 2'h0,
		RCC_CLK_RECV_REF  = 2'h1,
		RCC_CLK_RECV_RCVD = 2'h2,
		RCC_CLK_RSVD      = 2'h3
	} rcc_clk_t;

	typedef enum logic [1:0] {
		RCC_DEEMPH_OFF = 2'h0,
		RCC_DEEMPH_48  = 2'h1,
		RCC_DEEMPH_44  = 2'h2,
		RCC_DEEMPH_32  = 2'h3
	} rcc_deemph_t;

	typedef enum logic [1:0] {
		RCC_PAGE_CTRL = 2'h0,
		RCC_PAGE_RECV = 2'h1,
		RCC_PAGE_XMIT = 2'h2,
		RCC_PAGE_RSVD = 2'h3
	} rcc_page_t;

	typedef struct packed {
		logic [4:0]  ratioInteger;
		logic [10:0] ratioFraction;
	} rcc_ratio_t;

	typedef struct packed {
		rcc_src_t    inputSrc;
		rcc_clk_t    refClk;
		logic        mute;
		logic [7:0]  attenLeft;
		logic [7:0]  attenRight;
		logic [6:0]  preBufSamples;
		logic        directDown;
		rcc_deemph_t deemph;
		logic [4:0]  outWordBits;
		logic        ditherEn;
	} rcc_cfg_t;

	typedef struct packed {
		logic       wrEn;
		rcc_page_t  page;
		logic [6:0] addr;
		logic [7:0] data;
	} rcc_buf_wr_t;

endpackage

`default_nettype wire

// ---- rcc_sel_hold.sv ----
// selection holder: passes a written code on, keeps the last valid one on a reserved code
// assumes clk_sys and reset_n of the register bank
`timescale 1ns/1ps
`default_nettype none

module rcc_sel_hold #(
	parameter int         W        = 2,
	parameter logic [1:0] RESERVED = 2'h3
) (
	input  wire logic         clk_sys,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] code,
	output logic      [W-1:0] heldCode
);

	logic [W-1:0] held_r;
	logic [W-1:0] held_nxt;

	always_comb begin
		held_nxt = (code == RESERVED[W-1:0]) ? held_r : code;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			held_r <= '0;
		end else begin
			held_r <= held_nxt;
		end
	end

	assign heldCode = held_r;

endmodule

`default_nettype wire

// ---- rcc_control_regs_properties.sv ----
// checker for the rate converter control register bank
// assumes binding to rcc_control_regs; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module rcc_props (
	input wire logic                clk_sys,
	input wire logic                reset_n,
	input wire logic                hostWr,
	input wire logic                hostRd,
	input wire logic [6:0]          hostAddr,
	input wire logic [7:0]          hostWrData,
	input wire logic [7:0]          hostRdData,
	input wire logic                hostRdValid,
	input wire rcc_pkg::rcc_page_t  bufPage,
	input wire rcc_pkg::rcc_buf_wr_t bufWrite,
	input wire rcc_pkg::rcc_ratio_t ratioMeasured,
	input wire rcc_pkg::rcc_cfg_t   convCfg,
	input wire logic [1:0]          txProMode
);
	import rcc_pkg::*;
	// ==========
	// helpers and properties
	logic [7:0] capLow_r;
	logic [7:0] capLow_nxt;
	function automatic logic [4:0] wlenOf(input logic [1:0] c);
		return (c == 2'h0) ? 5'd24 : (c == 2'h1) ? 5'd20 : (c == 2'h2) ? 5'd18 : 5'd16;
	endfunction
	always_comb begin
		capLow_nxt = capLow_r;
		if (hostRd && hostAddr == 7'h32 && bufPage == RCC_PAGE_CTRL)
			capLow_nxt = ratioMeasured.ratioFraction[7:0];
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			capLow_r <= 8'h00;
		else
			capLow_r <= capLow_nxt;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence wrAt(logic [6:0] a);
		hostWr && hostAddr == a && bufPage == RCC_PAGE_CTRL;
	endsequence
	sequence rdAt(logic [6:0] a);
		hostRd && hostAddr == a && bufPage == RCC_PAGE_CTRL;
	endsequence
	AST_RD_PULSE: assert property (hostRd ##1 !hostRd |-> hostRdValid ##1 !hostRdValid)
		else $error("read answer not a one-cycle pulse");
	AST_MUTE: assert property (wrAt(7'h2D) |-> ##2 convCfg.mute == $past(hostWrData[4], 2))
		else $error("mute setting wrong");
	AST_PREBUF: assert property (wrAt(7'h2E) |-> ##2
		convCfg.preBufSamples == (7'd64 >> $past(hostWrData[1:0], 2)))
		else $error("pre-buffer depth wrong");
	AST_DEEMPH: assert property (wrAt(7'h2E) and !hostWrData[5] |-> ##2
		convCfg.deemph == $past(hostWrData[4:3], 2))
		else $error("manual de-emphasis wrong");
	AST_WLEN: assert property (wrAt(7'h2F) |-> ##2
		convCfg.outWordBits == wlenOf($past(hostWrData[7:6], 2)))
		else $error("word length wrong");
	AST_PAGE: assert property (hostWr && hostAddr == 7'h7F && hostWrData[1:0] != 2'h3
		|=> bufPage == $past(hostWrData[1:0]))
		else $error("page not taken");
	AST_PAGE_RSVD: assert property (hostWr && hostAddr == 7'h7F && hostWrData[1:0] == 2'h3
		|=> $stable(bufPage))
		else $error("reserved page took effect");
	AST_SEL_RSVD: assert property (convCfg.inputSrc != RCC_SRC_RSVD && convCfg.refClk != RCC_CLK_RSVD)
		else $error("reserved selection took effect");
	AST_RATIO_HI: assert property (rdAt(7'h32) |=> hostRdData ==
		{$past(ratioMeasured.ratioInteger), $past(ratioMeasured.ratioFraction[10:8])})
		else $error("ratio high byte wrong");
	AST_RATIO_LO: assert property (rdAt(7'h33) |=> hostRdData == capLow_r)
		else $error("ratio low byte not coherent");
	AST_BUF_WR: assert property (hostWr && bufPage == RCC_PAGE_RECV && hostAddr != 7'h7F
		|=> bufWrite.wrEn && bufWrite.addr == $past(hostAddr) && bufWrite.data == $past(hostWrData))
		else $error("buffer write not passed on");
	AST_CRC: assert property (hostWr && bufPage == RCC_PAGE_XMIT && hostAddr == 7'h2E && txProMode[0]
		|=> !bufWrite.wrEn)
		else $error("crc byte written in professional mode");
endmodule
`default_nettype wire

// ---- rcc_far_model.sv ----
// buffer memory side model answering page reads
// assumes the bank's bufPage and the host address
`timescale 1ns/1ps
`default_nettype none
module rcc_far_model (
	input wire rcc_pkg::rcc_page_t bufPage,
	input wire logic [6:0]         hostAddr,
	output logic      [7:0]        bufRdData
);
	import rcc_pkg::*;
	// ==========
	// page-dependent pattern
	assign bufRdData = {bufPage, hostAddr[5:0]} ^ 8'ha5;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// testbench for the rate converter control register bank
// assumes rcc_pkg, rcc_control_regs and rcc_far_model compiled before
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rcc_pkg::*;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic        hostWr = 1'b0;
	logic        hostRd = 1'b0;
	logic [6:0]  hostAddr = 7'h00;
	logic [7:0]  hostWrData = 8'h00;
	logic [7:0]  hostRdData;
	logic        hostRdValid;
	rcc_page_t   bufPage;
	rcc_buf_wr_t bufWrite;
	logic [7:0]  bufRdData;
	rcc_ratio_t  ratioMeasured = '0;
	logic [15:0] burstLenPreamble = 16'h0000;
	logic [7:0]  rxCsByte0 = 8'h00;
	logic [7:0]  rxCsByte3 = 8'h00;
	rcc_cfg_t    convCfg;
	logic [1:0]  txProMode;
	int          err_count = 0;
	int          check_count = 0;
	logic [6:0]  regAddr [6] = '{7'h2D, 7'h2E, 7'h2F, 7'h30, 7'h31, 7'h7F};
	logic [7:0]  regMask [6] = '{8'h5F, 8'h3F, 8'hC0, 8'hFF, 8'hFF, 8'h03};
	logic [4:0]  wlen [4] = '{5'd24, 5'd20, 5'd18, 5'd16};
	// ==========
	// clock, design, partner
	always #50 clk_sys = ~clk_sys;
	rcc_control_regs dut_u (.clk_sys, .reset_n, .hostWr, .hostRd, .hostAddr, .hostWrData,
		.hostRdData, .hostRdValid, .bufPage, .bufWrite, .bufRdData, .ratioMeasured,
		.burstLenPreamble, .rxCsByte0, .rxCsByte3, .convCfg, .txProMode);
	rcc_far_model far_u (.bufPage, .hostAddr, .bufRdData);
	// ==========
	// tasks
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		hostWr = 1'b1;
		hostAddr = a;
		hostWrData = d;
		@(negedge clk_sys);
		hostWr = 1'b0;
	endtask
	task automatic wrc(input logic [6:0] a, input logic [7:0] d);
		wr(a, d);
		repeat (2) @(negedge clk_sys);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		hostRd = 1'b1;
		hostAddr = a;
		@(negedge clk_sys);
		hostRd = 1'b0;
		chk(hostRdValid, 1'b1);
		chk(hostRdData, exp);
	endtask
	task automatic end_sim;
		if (err_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========
	// tests
	initial begin
		#(20000 * 100);
		err_count++;
		end_sim;
	end
	initial begin
		repeat (6) @(negedge clk_sys);
		reset_n = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk(convCfg.preBufSamples, 7'd64);
		foreach (regAddr[i]) rd(regAddr[i], 8'h00);
		foreach (regAddr[i]) begin
			wr(regAddr[i], 8'hFF);
			rd(regAddr[i], regMask[i]);
		end
		chk({bufPage, convCfg.inputSrc, convCfg.refClk}, 6'h00);
		foreach (regAddr[i]) wr(regAddr[i], 8'h00);
		for (int i = 0; i < 3; i++) begin
			wrc(7'h2D, {4'h0, i[1:0], i[1:0]});
			chk({convCfg.inputSrc, convCfg.refClk}, {i[1:0], i[1:0]});
		end
		wrc(7'h2D, 8'h1F);
		chk({convCfg.inputSrc, convCfg.refClk, convCfg.mute}, 5'h15);
		wr(7'h30, 8'h11);
		wrc(7'h31, 8'h22);
		chk({convCfg.mute, convCfg.attenLeft, convCfg.attenRight}, 17'h11122);
		wrc(7'h2D, 8'h40);
		chk(convCfg.attenRight, 8'h11);
		for (int i = 0; i < 4; i++) begin
			wr(7'h2F, {i[1:0], 6'h00});
			wrc(7'h2E, {3'h0, i[1:0], i[0], i[1:0]});
			chk(convCfg.preBufSamples, 7'd64 >> i);
			chk({convCfg.directDown, convCfg.deemph}, {i[0], i[1:0]});
			chk({convCfg.outWordBits, convCfg.ditherEn}, {wlen[i], i != 0});
		end
		rxCsByte0 = 8'hB9;
		wrc(7'h2E, 8'h38);
		chk(convCfg.deemph, RCC_DEEMPH_48);
		rxCsByte0 = 8'h00;
		repeat (2) @(negedge clk_sys);
		chk(convCfg.deemph, RCC_DEEMPH_OFF);
		rxCsByte0 = 8'h10;
		rxCsByte3 = 8'hC0;
		repeat (2) @(negedge clk_sys);
		chk(convCfg.deemph, RCC_DEEMPH_32);
		rxCsByte3 = 8'h40;
		repeat (2) @(negedge clk_sys);
		chk(convCfg.deemph, RCC_DEEMPH_48);
		rxCsByte0 = 8'h00;
		rxCsByte3 = 8'h00;
		ratioMeasured = 16'hABCD;
		rd(7'h32, 8'hAB);
		ratioMeasured = 16'h1234;
		rd(7'h33, 8'hCD);
		wr(7'h32, 8'h55);
		rd(7'h32, 8'h12);
		burstLenPreamble = 16'h5A3C;
		rd(7'h2C, 8'h3C);
		rd(7'h2B, 8'h5A);
		rd(7'h10, 8'h00);
		wr(7'h7F, 8'h02);
		chk(bufPage, RCC_PAGE_XMIT);
		wr(7'h05, 8'h77);
		chk(bufWrite, {1'b1, 2'h2, 7'h05, 8'h77});
		wr(7'h00, 8'h80);
		@(negedge clk_sys);
		chk(txProMode, 2'b01);
		wr(7'h2E, 8'h11);
		chk(bufWrite.wrEn, 1'b0);
		wr(7'h2F, 8'h11);
		chk(bufWrite.wrEn, 1'b1);
		rd(7'h03, 8'h26);
		rd(7'h7F, 8'h02);
		wr(7'h7F, 8'h01);
		wr(7'h10, 8'h5A);
		wr(7'h7F, 8'h00);
		chk(bufPage, RCC_PAGE_CTRL);
		reset_n = 1'b0;
		@(negedge clk_sys);
		reset_n = 1'b1;
		rd(7'h2D, 8'h00);
		end_sim;
	end
endmodule
bind rcc_control_regs rcc_props props_u (.clk_sys, .reset_n, .hostWr, .hostRd, .hostAddr,
	.hostWrData, .hostRdData, .hostRdValid, .bufPage, .bufWrite, .ratioMeasured, .convCfg,
	.txProMode);
`default_nettype wire
